/* cmp_ctrl_pkg.sv */
// Purpose: shared constants and carrier types for the comparator register bank
// Assumes: 8-bit special function register bus, one system clock
// Notes:   offsets are byte addresses on that bus
package cmp_ctrl_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CMP_A_MUX_OFS  = 8'h9c;
  localparam logic [7:0] CTRL_OFS       = 8'h9d;
  localparam logic [7:0] MODE_OFS       = 8'h9e;
  localparam logic [7:0] CMP_B_MUX_OFS  = 8'h9f;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_RESULT_BIT = 6;
  localparam int CTRL_RISE_BIT   = 5;
  localparam int CTRL_FALL_BIT   = 4;
  localparam int CTRL_HYP_LSB    = 2;
  localparam int CTRL_HYN_LSB    = 0;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_RIE_BIT    = 5;
  localparam int MODE_FIE_BIT    = 4;
  localparam int MODE_RESP_LSB   = 0;
  // unused bits 7:6 and 3:2 take no write and read as zero
  localparam logic [7:0] MODE_WMASK   = 8'h33;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] MODE_RESET   = 8'h02;
  localparam logic [7:0] MUX_RESET    = 8'h77;
  localparam logic [7:0] MUX_WMASK    = 8'hff;
  localparam logic [7:0] UNMAPPED_RD  = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic       cmp_enable;
    logic [1:0] hyst_pos_sel;
    logic [1:0] hyst_neg_sel;
    logic [1:0] response_mode_sel;
  } analog_cfg_s;

  typedef struct packed {
    logic [3:0] neg_input_sel;
    logic [3:0] pos_input_sel;
  } mux_sel_s;

endpackage

/* cmp_result_edge.sv */
// Purpose: bring the asynchronous comparator result onto the system clock
// Assumes: result may change at any time relative to clock_in
// Notes:   rise and fall are one-cycle pulses taken from synchronised stages
`timescale 1ns/1ns
module cmp_result_edge #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic raw_in,
  output logic      result_out,
  output logic      rise_out,
  output logic      fall_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync;
    logic                   last;
  } edge_state_s;

  edge_state_s st_q;
  edge_state_s st_d;

  // fewer than two stages would let a metastable level reach the edge logic
  if (SYNC_STAGES < 2)
  begin : g_stage_check
    $error("cmp_result_edge needs at least two sync stages");
  end

  // the first stage feeds only the next stage, never the edge logic
  always_comb
  begin
    st_d      = st_q;
    st_d.sync = {st_q.sync[SYNC_STAGES-2:0], raw_in};
    st_d.last = st_q.sync[SYNC_STAGES-1];
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign result_out = st_q.sync[SYNC_STAGES-1];
  assign rise_out   = st_q.sync[SYNC_STAGES-1] & ~st_q.last;
  assign fall_out   = ~st_q.sync[SYNC_STAGES-1] & st_q.last;

endmodule // cmp_result_edge

/* sfr_byte_reg.sv */
// Purpose: one plain read/write register byte with a write mask
// Assumes: write_in is already decoded for this register
// Notes:   masked bits hold their reset value for ever
`timescale 1ns/1ns
module sfr_byte_reg #(
  parameter logic [7:0] RESET_VAL  = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic       write_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] value_out
);

  typedef struct packed {
    logic [7:0] value;
  } byte_state_s;

  byte_state_s st_q;
  byte_state_s st_d;

  always_comb
  begin
    st_d = st_q;
    if (write_in)
      st_d.value = (wdata_in & WRITE_MASK) | (RESET_VAL & ~WRITE_MASK);
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      st_q.value <= RESET_VAL;
    else
      st_q <= st_d;
  end

  assign value_out = st_q.value;

endmodule // sfr_byte_reg

/* comparator_control_regs.sv */
// Purpose: control and status registers of the second comparator, plus
//          the input multiplexer selections of both comparators
// Assumes: 8-bit register bus on clock_in; result arrives asynchronously
// Notes:   all outputs come from flip-flops; read data lag one cycle
//
// Overview of operation
// - comparator runs only while enable set
// - bit 6 reads live comparator result
// - rising result sets rise flag, bit 5
// - rise flag sticks until software writes zero
// - falling result sets fall flag, bit 4
// - fall flag sticks until software writes zero
// - positive hysteresis field bits 3:2 driven out
// - negative hysteresis field bits 1:0 driven out
// - mode bit 5 enables rise interrupt
// - mode bit 4 enables fall interrupt
// - mode bits 1:0 select response speed
// - unused mode bits read zero, ignore writes
// - each comparator has 4-bit positive select
// - each comparator has 4-bit negative select
// - both multiplexers select pins independently
`timescale 1ns/1ns
module comparator_control_regs (
  input  wire logic                    clock_in,
  input  wire logic                    reset_in,
  input  wire cmp_ctrl_pkg::sfr_req_s  sfr_req_in,
  input  wire logic                    cmp_raw_in,
  output logic                  [7:0]  sfr_rdata_out,
  output cmp_ctrl_pkg::analog_cfg_s    cmp_b_cfg_out,
  output cmp_ctrl_pkg::mux_sel_s       cmp_a_mux_out,
  output cmp_ctrl_pkg::mux_sel_s       cmp_b_mux_out,
  output logic                         cmp_pin_out,
  output logic                         cmp_irq_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       cmp_enable;
    logic       cmp_rise_flag;
    logic       cmp_fall_flag;
    logic [1:0] hyst_pos_sel;
    logic [1:0] hyst_neg_sel;
    logic       pin;
    logic       irq;
    logic [7:0] rdata;
  } ctrl_state_s;

  ctrl_state_s st_q;
  ctrl_state_s st_d;

  logic       cmp_result;
  logic       rise_pulse;
  logic       fall_pulse;
  logic [7:0] mode_value;
  logic [7:0] mux_a_value;
  logic [7:0] mux_b_value;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_mux_a;
  logic       wr_mux_b;
  logic       rd_ctrl;
  logic       rd_mode;
  logic       rise_irq_enable;
  logic       fall_irq_enable;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  assign wr_ctrl  = sfr_req_in.wr & hit(sfr_req_in.addr,
                                        cmp_ctrl_pkg::CTRL_OFS);
  assign wr_mode  = sfr_req_in.wr & hit(sfr_req_in.addr,
                                        cmp_ctrl_pkg::MODE_OFS);
  assign wr_mux_a = sfr_req_in.wr & hit(sfr_req_in.addr,
                                        cmp_ctrl_pkg::CMP_A_MUX_OFS);
  assign wr_mux_b = sfr_req_in.wr & hit(sfr_req_in.addr,
                                        cmp_ctrl_pkg::CMP_B_MUX_OFS);
  assign rd_ctrl  = sfr_req_in.rd & hit(sfr_req_in.addr,
                                        cmp_ctrl_pkg::CTRL_OFS);
  assign rd_mode  = sfr_req_in.rd & hit(sfr_req_in.addr,
                                        cmp_ctrl_pkg::MODE_OFS);

  // ----------------------------------------------------------------
  // result synchroniser and edge pulses
  // ----------------------------------------------------------------
  cmp_result_edge #(
    .SYNC_STAGES (2)
  ) u_edge (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .raw_in     (cmp_raw_in),
    .result_out (cmp_result),
    .rise_out   (rise_pulse),
    .fall_out   (fall_pulse)
  );

  // ----------------------------------------------------------------
  // mode and multiplexer registers
  // ----------------------------------------------------------------
  sfr_byte_reg #(
    .RESET_VAL  (cmp_ctrl_pkg::MODE_RESET),
    .WRITE_MASK (cmp_ctrl_pkg::MODE_WMASK)
  ) u_mode (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .write_in  (wr_mode),
    .wdata_in  (sfr_req_in.wdata),
    .value_out (mode_value)
  );

  // separate storage per comparator, so one select never touches the other
  sfr_byte_reg #(
    .RESET_VAL  (cmp_ctrl_pkg::MUX_RESET),
    .WRITE_MASK (cmp_ctrl_pkg::MUX_WMASK)
  ) u_mux_a (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .write_in  (wr_mux_a),
    .wdata_in  (sfr_req_in.wdata),
    .value_out (mux_a_value)
  );

  sfr_byte_reg #(
    .RESET_VAL  (cmp_ctrl_pkg::MUX_RESET),
    .WRITE_MASK (cmp_ctrl_pkg::MUX_WMASK)
  ) u_mux_b (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .write_in  (wr_mux_b),
    .wdata_in  (sfr_req_in.wdata),
    .value_out (mux_b_value)
  );

  assign rise_irq_enable = mode_value[cmp_ctrl_pkg::MODE_RIE_BIT];
  assign fall_irq_enable = mode_value[cmp_ctrl_pkg::MODE_FIE_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    if (wr_ctrl)
    begin
      st_d.cmp_enable   = sfr_req_in.wdata[cmp_ctrl_pkg::CTRL_ENABLE_BIT];
      st_d.hyst_pos_sel = sfr_req_in.wdata[cmp_ctrl_pkg::CTRL_HYP_LSB +: 2];
      st_d.hyst_neg_sel = sfr_req_in.wdata[cmp_ctrl_pkg::CTRL_HYN_LSB +: 2];
      st_d.cmp_rise_flag = sfr_req_in.wdata[cmp_ctrl_pkg::CTRL_RISE_BIT];
      st_d.cmp_fall_flag = sfr_req_in.wdata[cmp_ctrl_pkg::CTRL_FALL_BIT];
    end
    // an edge in the same cycle as a clearing write still sets the flag
    if (rise_pulse)
      st_d.cmp_rise_flag = 1'b1;
    if (fall_pulse)
      st_d.cmp_fall_flag = 1'b1;

    // a disabled comparator routed to a pin shows low
    st_d.pin = st_q.cmp_enable & cmp_result;

    st_d.irq = (st_q.cmp_rise_flag & rise_irq_enable) |
               (st_q.cmp_fall_flag & fall_irq_enable);

    if (sfr_req_in.rd)
    begin
      unique case (1'b1)
        rd_ctrl:
          st_d.rdata = {st_q.cmp_enable, cmp_result,
                        st_q.cmp_rise_flag, st_q.cmp_fall_flag,
                        st_q.hyst_pos_sel, st_q.hyst_neg_sel};
        rd_mode:
          st_d.rdata = mode_value & cmp_ctrl_pkg::MODE_WMASK;
        hit(sfr_req_in.addr, cmp_ctrl_pkg::CMP_A_MUX_OFS):
          st_d.rdata = mux_a_value;
        hit(sfr_req_in.addr, cmp_ctrl_pkg::CMP_B_MUX_OFS):
          st_d.rdata = mux_b_value;
        default:
          st_d.rdata = cmp_ctrl_pkg::UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      st_q       <= '0;
      st_q.rdata <= cmp_ctrl_pkg::CTRL_RESET;
    end
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sfr_rdata_out = st_q.rdata;
  assign cmp_pin_out   = st_q.pin;
  assign cmp_irq_out   = st_q.irq;

  assign cmp_b_cfg_out.cmp_enable        = st_q.cmp_enable;
  assign cmp_b_cfg_out.hyst_pos_sel      = st_q.hyst_pos_sel;
  assign cmp_b_cfg_out.hyst_neg_sel      = st_q.hyst_neg_sel;
  assign cmp_b_cfg_out.response_mode_sel =
    mode_value[cmp_ctrl_pkg::MODE_RESP_LSB +: 2];

  assign cmp_a_mux_out = mux_a_value;
  assign cmp_b_mux_out = mux_b_value;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  rise_sets_a: assert property (
    rise_pulse |=> st_q.cmp_rise_flag)
    else $error("rise flag not set after rising result");

  fall_sets_a: assert property (
    fall_pulse |=> st_q.cmp_fall_flag)
    else $error("fall flag not set after falling result");

  rise_sticky_a: assert property (
    (st_q.cmp_rise_flag &&
     !(wr_ctrl && !sfr_req_in.wdata[cmp_ctrl_pkg::CTRL_RISE_BIT]))
    |=> st_q.cmp_rise_flag)
    else $error("rise flag dropped without a clearing write");

  fall_sticky_a: assert property (
    (st_q.cmp_fall_flag &&
     !(wr_ctrl && !sfr_req_in.wdata[cmp_ctrl_pkg::CTRL_FALL_BIT]))
    |=> st_q.cmp_fall_flag)
    else $error("fall flag dropped without a clearing write");

  result_read_a: assert property (
    rd_ctrl |=> sfr_rdata_out[cmp_ctrl_pkg::CTRL_RESULT_BIT] ==
                $past(cmp_result))
    else $error("control read does not show the result");

  irq_on_a: assert property (
    ((st_q.cmp_rise_flag && rise_irq_enable) ||
     (st_q.cmp_fall_flag && fall_irq_enable)) |=> cmp_irq_out)
    else $error("interrupt missing with an enabled flag set");

  irq_off_a: assert property (
    !((st_q.cmp_rise_flag && rise_irq_enable) ||
      (st_q.cmp_fall_flag && fall_irq_enable)) |=> !cmp_irq_out)
    else $error("interrupt raised with no enabled flag set");

  mode_unused_a: assert property (
    rd_mode |=> (sfr_rdata_out[7:6] == 2'h0 && sfr_rdata_out[3:2] == 2'h0))
    else $error("unused mode bits read nonzero");

  pin_low_a: assert property (
    !st_q.cmp_enable ##1 !st_q.cmp_enable |-> !cmp_pin_out)
    else $error("disabled comparator drives its pin high");

  single_edge_a: assert property (
    rise_pulse |=> !rise_pulse && !fall_pulse)
    else $error("one transition gave more than one edge");

  mux_indep_a: assert property (
    (wr_mux_a && !wr_mux_b) |=> $stable(cmp_b_mux_out))
    else $error("write to one multiplexer altered the other");

  hyst_drive_a: assert property (
    wr_ctrl |=> cmp_b_cfg_out.hyst_pos_sel ==
                $past(sfr_req_in.wdata[3:2]))
    else $error("positive hysteresis not driven from write");

  mode_drive_a: assert property (
    wr_mode |=> cmp_b_cfg_out.response_mode_sel ==
                $past(sfr_req_in.wdata[1:0]))
    else $error("response mode not driven from write");

  hyst_neg_drive_a: assert property (
    wr_ctrl |=> cmp_b_cfg_out.hyst_neg_sel ==
                $past(sfr_req_in.wdata[1:0]))
    else $error("negative hysteresis not driven from write");

  enable_drive_a: assert property (
    wr_ctrl |=> cmp_b_cfg_out.cmp_enable ==
                $past(sfr_req_in.wdata[7]))
    else $error("enable not driven from write");

  irq_fall_a: assert property (
    (st_q.cmp_fall_flag && fall_irq_enable) |=> cmp_irq_out)
    else $error("fall interrupt missing with its enable set");

  mux_a_drive_a: assert property (
    wr_mux_a |=> cmp_a_mux_out == $past(sfr_req_in.wdata))
    else $error("multiplexer A select not driven from write");

  mux_b_drive_a: assert property (
    wr_mux_b |=> cmp_b_mux_out == $past(sfr_req_in.wdata))
    else $error("multiplexer B select not driven from write");

endmodule // comparator_control_regs

/* cmp_core_model.sv */
// Purpose: behavioural analog comparator core facing the register bank
// Assumes: the bench sets which input is higher through pos_above_neg_in
// Notes:   response delay grows with the response mode code
`timescale 1ns/1ns
module cmp_core_model (
  input  wire cmp_ctrl_pkg::analog_cfg_s cfg_in,
  input  wire logic                      pos_above_neg_in,
  output logic                           raw_out
);
  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  initial raw_out = 1'b0;

  // a powered-down core sits low, so enabling it may show a false edge
  always @(cfg_in or pos_above_neg_in)
  begin
    raw_out <= #(10 * (int'(cfg_in.response_mode_sel) + 1))
      cfg_in.cmp_enable & pos_above_neg_in;
  end
endmodule // cmp_core_model

/* comparator_control_regs_tb_top.sv */
// Purpose: self-checking bench for the comparator register bank
// Assumes: one 25 MHz clock, bench drives 1 ns after each rising edge
// Notes:   flag latencies are taken with an 8 cycle settle margin
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    checked = checked + 1; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch = n_mismatch + 1; \
      $display("BAD t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module comparator_control_regs_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                        clock_in;
  logic                        reset_in;
  cmp_ctrl_pkg::sfr_req_s      req;
  logic                        level;
  logic                        raw;
  logic [7:0]                  rdata;
  cmp_ctrl_pkg::analog_cfg_s   cfg;
  cmp_ctrl_pkg::mux_sel_s      mux_a;
  cmp_ctrl_pkg::mux_sel_s      mux_b;
  logic                        pin;
  logic                        irq;
  int                          n_mismatch;
  int                          checked;

  comparator_control_regs DUT (
    .clock_in      (clock_in),
    .reset_in      (reset_in),
    .sfr_req_in    (req),
    .cmp_raw_in    (raw),
    .sfr_rdata_out (rdata),
    .cmp_b_cfg_out (cfg),
    .cmp_a_mux_out (mux_a),
    .cmp_b_mux_out (mux_b),
    .cmp_pin_out   (pin),
    .cmp_irq_out   (irq)
  );

  cmp_core_model u_core (
    .cfg_in           (cfg),
    .pos_above_neg_in (level),
    .raw_out          (raw)
  );

  always #20 clock_in = ~clock_in;

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge clock_in);
    #1;
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clock_in);
    #1;
    req.rd = 1'b0;
    `CHK(rdata, exp)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // bounded wait, so a stuck request line cannot hang the run
  task automatic wait_irq(input logic exp);
    int k;
    k = 0;
    while (irq !== exp && k < 10)
    begin
      @(posedge clock_in);
      #1;
      k++;
    end
    `CHK(irq, exp)
  endtask

  task automatic end_of_test;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    reset_in = 1'b1;
    req = '0;
    level = 1'b0;
    n_mismatch = 0;
    checked = 0;
    repeat (5) @(posedge clock_in);
    #1;
    reset_in = 1'b0;
    rd(cmp_ctrl_pkg::CTRL_OFS, cmp_ctrl_pkg::CTRL_RESET);
    rd(cmp_ctrl_pkg::MODE_OFS, cmp_ctrl_pkg::MODE_RESET);
    rd(cmp_ctrl_pkg::CMP_A_MUX_OFS, cmp_ctrl_pkg::MUX_RESET);
    rd(cmp_ctrl_pkg::CMP_B_MUX_OFS, cmp_ctrl_pkg::MUX_RESET);
    rd(8'ha0, cmp_ctrl_pkg::UNMAPPED_RD);
    `CHK(pin, 1'b0)
    `CHK(irq, 1'b0)
    for (int i = 0; i < 4; i++)
    begin
      wr(cmp_ctrl_pkg::CTRL_OFS, {4'h0, 2'(i), 2'(3 - i)});
      `CHK(cfg.hyst_pos_sel, 2'(i))
      `CHK(cfg.hyst_neg_sel, 2'(3 - i))
      `CHK(cfg.cmp_enable, 1'b0)
      rd(cmp_ctrl_pkg::CTRL_OFS, {4'h0, 2'(i), 2'(3 - i)});
    end
    // unused bits are written as ones to prove they are dropped
    for (int i = 0; i < 4; i++)
    begin
      wr(cmp_ctrl_pkg::MODE_OFS, {6'h33, 2'(i)});
      `CHK(cfg.response_mode_sel, 2'(i))
      rd(cmp_ctrl_pkg::MODE_OFS, {6'h00, 2'(i)});
    end
    wr(cmp_ctrl_pkg::MODE_OFS, 8'hff);
    rd(cmp_ctrl_pkg::MODE_OFS, 8'h33);
    // the bench level input stands for pins already set up as analog inputs
    wr(cmp_ctrl_pkg::CMP_A_MUX_OFS, 8'h5a);
    `CHK(mux_a, 8'h5a)
    `CHK(mux_b, cmp_ctrl_pkg::MUX_RESET)
    wr(cmp_ctrl_pkg::CMP_B_MUX_OFS, 8'h5a);
    `CHK(mux_b.pos_input_sel, 4'ha)
    `CHK(mux_b.neg_input_sel, 4'h5)
    wr(cmp_ctrl_pkg::CMP_B_MUX_OFS, 8'hc3);
    rd(cmp_ctrl_pkg::CMP_A_MUX_OFS, 8'h5a);
    rd(cmp_ctrl_pkg::CMP_B_MUX_OFS, 8'hc3);
    wr(cmp_ctrl_pkg::MODE_OFS, 8'h00);
    wr(cmp_ctrl_pkg::CTRL_OFS, 8'h80);
    settle(8);
    wr(cmp_ctrl_pkg::CTRL_OFS, 8'h80);
    level = 1'b1;
    settle(8);
    rd(cmp_ctrl_pkg::CTRL_OFS, 8'he0);
    `CHK(pin, 1'b1)
    `CHK(irq, 1'b0)
    settle(8);
    rd(cmp_ctrl_pkg::CTRL_OFS, 8'he0);
    wr(cmp_ctrl_pkg::MODE_OFS, 8'h20);
    wait_irq(1'b1);
    wr(cmp_ctrl_pkg::CTRL_OFS, 8'h80);
    rd(cmp_ctrl_pkg::CTRL_OFS, 8'hc0);
    wait_irq(1'b0);
    level = 1'b0;
    settle(8);
    rd(cmp_ctrl_pkg::CTRL_OFS, 8'h90);
    `CHK(irq, 1'b0)
    wr(cmp_ctrl_pkg::MODE_OFS, 8'h10);
    wait_irq(1'b1);
    settle(8);
    rd(cmp_ctrl_pkg::CTRL_OFS, 8'h90);
    wr(cmp_ctrl_pkg::CTRL_OFS, 8'h80);
    rd(cmp_ctrl_pkg::CTRL_OFS, 8'h80);
    wait_irq(1'b0);
    // slowest response mode still sets the rise flag and leaves the fall flag clear
    wr(cmp_ctrl_pkg::MODE_OFS, 8'h03);
    level = 1'b1;
    settle(8);
    rd(cmp_ctrl_pkg::CTRL_OFS, 8'he0);
    wr(cmp_ctrl_pkg::CTRL_OFS, 8'h00);
    settle(8);
    rd(cmp_ctrl_pkg::CTRL_OFS, 8'h10);
    `CHK(pin, 1'b0)
    // a second reset in mid-run must drop the sticky flag and the multiplexer B select
    reset_in = 1'b1;
    settle(5);
    reset_in = 1'b0;
    rd(cmp_ctrl_pkg::CTRL_OFS, cmp_ctrl_pkg::CTRL_RESET);
    rd(cmp_ctrl_pkg::CMP_B_MUX_OFS, cmp_ctrl_pkg::MUX_RESET);
    `CHK(irq, 1'b0)
    end_of_test;
  end

  initial
  begin
    #200000;
    n_mismatch = n_mismatch + 1;
    $display("BAD t=%0t watchdog expired", $time);
    end_of_test;
  end
endmodule // comparator_control_regs_tb_top
